// ===== hw/bsfs_consts.svh
// constants for the boot select and flash security block
// assumes inclusion by bare name from any file of the block
`ifndef BSFS_CONSTS_SVH
`define BSFS_CONSTS_SVH

// flash program control command values
`define BSFS_FPC_RESET 8'h00
`define BSFS_FPC_LOADER_ENTRY 8'h03
`define BSFS_FPC_LOADER_UPDATE 8'h01
`define BSFS_FPC_SW_RESTART 8'h83

// security option bit positions
`define BSFS_OPT_LOCK 0
`define BSFS_OPT_CTR_INHIBIT 1
`define BSFS_OPT_REBOOT_AB 4
`define BSFS_OPT_REBOOT_C 5

// security option erased value
`define BSFS_OPT_RESET 8'hFF

`endif

// ===== hw/bsfs_pkg.sv
// types shared by the boot select and flash security block
// assumes nothing beyond a SystemVerilog compiler
package bsfs_pkg;

    // gray along app -> loader; update is one bit from app as well
    typedef enum logic [1:0] {
        BSFS_ST_APP = 2'b00,
        BSFS_ST_LDR = 2'b01,
        BSFS_ST_UPD = 2'b10
    } bsfs_state_t;

endpackage

// ===== hw/bsfs_option_store.sv
// security option register, reachable only by the external programmer
// assumes programmer strobes are synchronous to clk and one cycle long
`timescale 1ns/1ps
`default_nettype none
`include "bsfs_consts.svh"

module bsfs_option_store import bsfs_pkg::*; #(
    parameter int OPT_W = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic prog_mode,
    input wire logic prog_wr,
    input wire logic prog_rd,
    input wire logic prog_erase_all,
    input wire logic [OPT_W-1:0] prog_wdata,
    output logic [OPT_W-1:0] prog_rdata,
    output logic prog_refused,
    output logic [OPT_W-1:0] opt
);

    logic unlocked;
    logic access_ok;

    assign unlocked = opt[`BSFS_OPT_LOCK];
    assign access_ok = prog_mode & unlocked;

    // flops stand in for the non-volatile cells; arst_n models a blank part
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            opt <= OPT_W'(`BSFS_OPT_RESET); // R9
        end else if (clk_en) begin
            if (prog_mode && prog_erase_all) begin
                // erase-all is the only way back to ones, even when locked
                opt <= OPT_W'(`BSFS_OPT_RESET); // R9
            end else if (prog_wr && access_ok) begin
                // programming can only pull bits low
                opt <= opt & prog_wdata; // R9 R8 R10
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prog_rdata <= '0;
        end else if (clk_en) begin
            if (prog_rd) begin
                prog_rdata <= access_ok ? opt : '0; // R8 R10
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prog_refused <= 1'b0;
        end else if (clk_en) begin
            prog_refused <= (prog_rd | (prog_wr & ~prog_erase_all)) & ~access_ok; // R8 R10
        end
    end

endmodule // bsfs_option_store

`default_nettype wire

// ===== hw/bsfs_top.sv
// boot source selection, in-system loader switching and code protection
// assumes all inputs synchronous to clk; ext_reset is the reset pin level
`timescale 1ns/1ps
`default_nettype none
`include "bsfs_consts.svh"

// Contract
// [R1] after external reset, fetch from application flash unless reboot selects loader
// [R2] option bit 4 low, reset high, straps a and b low: boot loader
// [R3] option bit 5 low, reset high, strap c low: boot loader
// [R4] board pulls straps high and keeps them safe during reset
// [R5] control register 03h at idle: switch fetch to loader and reset
// [R6] writing 83h from loader: software reset back to application flash
// [R7] control register 01h at idle: stay in application, update loader, continue
// [R8] option register reachable only in programmer mode, never from normal execution
// [R9] option bits default to one; only full erase returns them to one
// [R10] lock bit low refuses all flash and option register access; erase-all in programmer mode is still taken when locked
// [R11] inhibit bit low: table read from external code reaches external only
// [R12] table read from internal code reaches all; inhibit high: unrestricted
// [R13] straps sampled during reset; boot source held until reset or switch
module bsfs_top import bsfs_pkg::*; #(
    parameter int OPT_W = 8,
    parameter int FPC_W = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic ext_reset,
    input wire logic strap_pin_a,
    input wire logic strap_pin_b,
    input wire logic strap_pin_c,
    input wire logic cpu_idle,
    input wire logic fpc_wr,
    input wire logic [FPC_W-1:0] fpc_wdata,
    output logic [FPC_W-1:0] fpc_rdata,
    input wire logic ldr_update_done,
    output logic fetch_from_loader,
    output logic ldr_update_active,
    output logic sys_reset_req,
    input wire logic prog_mode,
    input wire logic prog_wr,
    input wire logic prog_rd,
    input wire logic prog_erase_all,
    input wire logic [OPT_W-1:0] prog_wdata,
    output logic [OPT_W-1:0] prog_rdata,
    output logic prog_refused,
    output logic flash_access_ok,
    input wire logic ctr_req,
    input wire logic ctr_exec_ext,
    input wire logic ctr_target_int,
    output logic ctr_valid,
    output logic ctr_to_internal,
    output logic ctr_redirected
);

    bsfs_state_t state;
    logic [FPC_W-1:0] flash_program_control;
    logic [OPT_W-1:0] opt;
    logic reboot_ab;
    logic reboot_c;
    logic reboot_cond;
    logic idle_enter_ldr;
    logic idle_update_ldr;
    logic sw_restart;
    logic ctr_int_allowed;

    bsfs_option_store #(
        .OPT_W(OPT_W)
    ) u_opt (
        .clk(clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .prog_mode(prog_mode),
        .prog_wr(prog_wr),
        .prog_rd(prog_rd),
        .prog_erase_all(prog_erase_all),
        .prog_wdata(prog_wdata),
        .prog_rdata(prog_rdata),
        .prog_refused(prog_refused),
        .opt(opt)
    );

    // straps are pulled high on the board, so a floating pin never reboots
    assign reboot_ab = ~opt[`BSFS_OPT_REBOOT_AB] & ~strap_pin_a & ~strap_pin_b; // R2 R4
    assign reboot_c = ~opt[`BSFS_OPT_REBOOT_C] & ~strap_pin_c; // R3 R4
    assign reboot_cond = reboot_ab | reboot_c;

    assign idle_enter_ldr = (state == BSFS_ST_APP) & cpu_idle
        & (flash_program_control == FPC_W'(`BSFS_FPC_LOADER_ENTRY));
    assign idle_update_ldr = (state == BSFS_ST_APP) & cpu_idle
        & (flash_program_control == FPC_W'(`BSFS_FPC_LOADER_UPDATE));
    assign sw_restart = (state == BSFS_ST_LDR) & fpc_wr
        & (fpc_wdata == FPC_W'(`BSFS_FPC_SW_RESTART));

    // boot source; ext_reset overrides everything so straps are sampled
    // for as long as the pin is held and the last sample is kept
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= BSFS_ST_APP; // R1
        end else if (clk_en) begin
            if (ext_reset) begin
                state <= reboot_cond ? BSFS_ST_LDR : BSFS_ST_APP; // R1 R2 R3 R13
            end else begin
                unique case (state)
                    BSFS_ST_APP: begin
                        if (idle_enter_ldr) begin
                            state <= BSFS_ST_LDR; // R5
                        end else if (idle_update_ldr) begin
                            state <= BSFS_ST_UPD; // R7
                        end
                    end
                    BSFS_ST_LDR: begin
                        if (sw_restart) begin
                            state <= BSFS_ST_APP; // R6
                        end
                    end
                    BSFS_ST_UPD: begin
                        if (ldr_update_done) begin
                            state <= BSFS_ST_APP; // R7
                        end
                    end
                    default: begin
                        state <= BSFS_ST_APP;
                    end
                endcase
            end
        end
    end

    // command is consumed when it acts, 01h when its update is done, so a later idle does not repeat it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flash_program_control <= FPC_W'(`BSFS_FPC_RESET);
        end else if (clk_en) begin
            if (ext_reset || idle_enter_ldr || sw_restart) begin
                flash_program_control <= FPC_W'(`BSFS_FPC_RESET);
            end else if (state == BSFS_ST_UPD && ldr_update_done) begin
                flash_program_control <= FPC_W'(`BSFS_FPC_RESET);
            end else if (fpc_wr) begin
                flash_program_control <= fpc_wdata;
            end
        end
    end

    assign fpc_rdata = flash_program_control;

    // one-cycle core reset request; the loader update keeps the core running
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sys_reset_req <= 1'b0;
        end else if (clk_en) begin
            sys_reset_req <= ~ext_reset & (idle_enter_ldr | sw_restart); // R5 R6 R7
        end
    end

    assign fetch_from_loader = (state == BSFS_ST_LDR);
    assign ldr_update_active = (state == BSFS_ST_UPD);
    // flash array access for the programmer is gated by the lock bit
    assign flash_access_ok = prog_mode & opt[`BSFS_OPT_LOCK]; // R8 R10

    // table reads from internal code are never restricted
    assign ctr_int_allowed = ~ctr_exec_ext | opt[`BSFS_OPT_CTR_INHIBIT]; // R11 R12

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctr_valid <= 1'b0;
            ctr_to_internal <= 1'b0;
            ctr_redirected <= 1'b0;
        end else if (clk_en) begin
            ctr_valid <= ctr_req;
            if (ctr_req) begin
                ctr_to_internal <= ctr_target_int & ctr_int_allowed; // R11 R12
                ctr_redirected <= ctr_target_int & ~ctr_int_allowed; // R11
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_default_app;
        clk_en && ext_reset && !reboot_cond |=> !fetch_from_loader && !ldr_update_active;
    endproperty
    a_default_app: assert property (p_default_app) // R1
        else $error("boot did not select application flash");

    property p_reboot_ab;
        clk_en && ext_reset && !opt[`BSFS_OPT_REBOOT_AB] && !strap_pin_a && !strap_pin_b
            |=> fetch_from_loader;
    endproperty
    a_reboot_ab: assert property (p_reboot_ab) // R2
        else $error("strap a/b reboot did not select loader");

    property p_reboot_c;
        clk_en && ext_reset && !opt[`BSFS_OPT_REBOOT_C] && !strap_pin_c |=> fetch_from_loader;
    endproperty
    a_reboot_c: assert property (p_reboot_c) // R3
        else $error("strap c reboot did not select loader");

    property p_idle_loader;
        clk_en && !ext_reset && state == BSFS_ST_APP && cpu_idle
            && flash_program_control == FPC_W'(`BSFS_FPC_LOADER_ENTRY)
            |=> sys_reset_req && fetch_from_loader;
    endproperty
    a_idle_loader: assert property (p_idle_loader) // R5
        else $error("idle with 03h did not enter loader with reset");

    property p_sw_restart;
        clk_en && !ext_reset && fetch_from_loader && fpc_wr
            && fpc_wdata == FPC_W'(`BSFS_FPC_SW_RESTART)
            |=> sys_reset_req && !fetch_from_loader;
    endproperty
    a_sw_restart: assert property (p_sw_restart) // R6
        else $error("83h from loader did not restart in application");

    property p_idle_update;
        clk_en && !ext_reset && state == BSFS_ST_APP && cpu_idle
            && flash_program_control == FPC_W'(`BSFS_FPC_LOADER_UPDATE)
            |=> ldr_update_active && !sys_reset_req && !fetch_from_loader;
    endproperty
    a_idle_update: assert property (p_idle_update) // R7
        else $error("idle with 01h did not start loader update in place");

    property p_normal_refused;
        clk_en && !prog_mode && (prog_rd || (prog_wr && !prog_erase_all))
            |=> prog_refused && $stable(opt);
    endproperty
    a_normal_refused: assert property (p_normal_refused) // R8
        else $error("option register reached outside programmer mode");

    property p_one_way;
        !(clk_en && prog_mode && prog_erase_all) |=> (opt & ~$past(opt)) == '0;
    endproperty
    a_one_way: assert property (p_one_way) // R9
        else $error("option bit returned to one without erase");

    property p_lock;
        clk_en && !opt[`BSFS_OPT_LOCK] && prog_rd |=> prog_refused && prog_rdata == '0;
    endproperty
    a_lock: assert property (p_lock) // R10
        else $error("locked option register was readable");

    property p_ctr_inhibit;
        clk_en && ctr_req && ctr_exec_ext && !opt[`BSFS_OPT_CTR_INHIBIT]
            |=> ctr_valid && !ctr_to_internal && ctr_redirected == $past(ctr_target_int);
    endproperty
    a_ctr_inhibit: assert property (p_ctr_inhibit) // R11
        else $error("inhibited table read reached internal flash");

    property p_ctr_free;
        clk_en && ctr_req && (!ctr_exec_ext || opt[`BSFS_OPT_CTR_INHIBIT])
            |=> ctr_to_internal == $past(ctr_target_int) && !ctr_redirected;
    endproperty
    a_ctr_free: assert property (p_ctr_free) // R12
        else $error("unrestricted table read was redirected");

    property p_hold_loader;
        clk_en && !ext_reset && fetch_from_loader && !sw_restart |=> fetch_from_loader;
    endproperty
    a_hold_loader: assert property (p_hold_loader) // R13
        else $error("loader boot source not held");

    property p_hold_app;
        clk_en && !ext_reset && !fetch_from_loader && !idle_enter_ldr |=> !fetch_from_loader;
    endproperty
    a_hold_app: assert property (p_hold_app) // R13
        else $error("application boot source not held");

    // a frozen clock must not move the boot source or the option bits
    property p_freeze;
        !clk_en |=> $stable(state) && $stable(opt) && $stable(flash_program_control)
            && $stable(sys_reset_req) && $stable(ctr_valid);
    endproperty
    a_freeze: assert property (p_freeze) // R13
        else $error("state moved while clock enable was low");

    property p_ext_reset_clears;
        clk_en && ext_reset |=> fpc_rdata == FPC_W'(`BSFS_FPC_RESET) && !sys_reset_req;
    endproperty
    a_ext_reset_clears: assert property (p_ext_reset_clears) // R1
        else $error("external reset left a command or reset request behind");

    property p_restart_outside;
        clk_en && !ext_reset && !fetch_from_loader && !cpu_idle && fpc_wr
            && fpc_wdata == FPC_W'(`BSFS_FPC_SW_RESTART)
            |=> !sys_reset_req && !fetch_from_loader;
    endproperty
    a_restart_outside: assert property (p_restart_outside) // R6
        else $error("83h outside the loader caused a restart");

    property p_update_hold;
        clk_en && !ext_reset && ldr_update_active && !ldr_update_done
            |=> ldr_update_active && !fetch_from_loader;
    endproperty
    a_update_hold: assert property (p_update_hold) // R7
        else $error("loader update left before it was done");

    property p_update_end;
        clk_en && !ext_reset && ldr_update_active && ldr_update_done
            |=> !ldr_update_active && !fetch_from_loader
            && fpc_rdata == FPC_W'(`BSFS_FPC_RESET);
    endproperty
    a_update_end: assert property (p_update_end) // R7
        else $error("loader update did not return to the application");

    property p_erase_all;
        clk_en && prog_mode && prog_erase_all |=> opt == OPT_W'(`BSFS_OPT_RESET);
    endproperty
    a_erase_all: assert property (p_erase_all) // R9
        else $error("erase-all did not restore the option bits");

    property p_lock_write;
        clk_en && !opt[`BSFS_OPT_LOCK] && prog_wr && !prog_erase_all
            |=> prog_refused && $stable(opt);
    endproperty
    a_lock_write: assert property (p_lock_write) // R10
        else $error("locked option register was written");

endmodule // bsfs_top

`default_nettype wire

// ===== test/bsfs_board_model.sv
// board side model: strap pins with pull-ups and optional switches
// assumes the switch inputs change just after a rising clk edge
`timescale 1ns/1ps
`default_nettype none
module bsfs_board_model (
    input wire logic clk,
    input wire logic ext_reset,
    input wire logic press_a,
    input wire logic press_b,
    input wire logic press_c,
    output logic strap_pin_a,
    output logic strap_pin_b,
    output logic strap_pin_c
);
    logic [2:0] held = 3'h0;
    // switches are only taken outside reset, so straps stay put while it is asserted
    always @(posedge clk) begin
        if (!ext_reset) begin
            held <= {press_c, press_b, press_a};
        end
    end
    // pull-ups: a released switch reads high
    assign strap_pin_a = ~held[0];
    assign strap_pin_b = ~held[1];
    assign strap_pin_c = ~held[2];
endmodule // bsfs_board_model
`default_nettype wire

// ===== test/tb_bsfs_top.sv
// self-checking bench for the boot select and flash security block
// assumes the board model drives the straps; programmer and cpu are tasks here
`timescale 1ns/1ps
`default_nettype none
`include "bsfs_consts.svh"
module tb_bsfs_top import bsfs_pkg::*;;
    logic clk = 1'b0;
    logic clk_en = 1'b1;
    logic arst_n = 1'b0;
    logic ext_reset = 1'b0, cpu_idle = 1'b0, fpc_wr = 1'b0, ldr_update_done = 1'b0;
    logic prog_mode = 1'b0, prog_wr = 1'b0, prog_rd = 1'b0, prog_erase_all = 1'b0;
    logic ctr_req = 1'b0, ctr_exec_ext = 1'b0, ctr_target_int = 1'b0;
    logic press_a = 1'b0, press_b = 1'b0, press_c = 1'b0;
    logic [7:0] fpc_wdata = 8'h00, prog_wdata = 8'h00;
    logic strap_pin_a, strap_pin_b, strap_pin_c;
    logic [7:0] fpc_rdata, prog_rdata;
    logic fetch_from_loader, ldr_update_active, sys_reset_req, prog_refused;
    logic flash_access_ok, ctr_valid, ctr_to_internal, ctr_redirected;
    int error_cnt = 0;
    int checked = 0;

    always #20 clk = ~clk;

    bsfs_board_model board (.clk(clk), .ext_reset(ext_reset), .press_a(press_a),
        .press_b(press_b), .press_c(press_c), .strap_pin_a(strap_pin_a),
        .strap_pin_b(strap_pin_b), .strap_pin_c(strap_pin_c));

    bsfs_top DUT (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .ext_reset(ext_reset),
        .strap_pin_a(strap_pin_a), .strap_pin_b(strap_pin_b), .strap_pin_c(strap_pin_c),
        .cpu_idle(cpu_idle), .fpc_wr(fpc_wr), .fpc_wdata(fpc_wdata), .fpc_rdata(fpc_rdata),
        .ldr_update_done(ldr_update_done), .fetch_from_loader(fetch_from_loader),
        .ldr_update_active(ldr_update_active), .sys_reset_req(sys_reset_req),
        .prog_mode(prog_mode), .prog_wr(prog_wr), .prog_rd(prog_rd),
        .prog_erase_all(prog_erase_all), .prog_wdata(prog_wdata), .prog_rdata(prog_rdata),
        .prog_refused(prog_refused), .flash_access_ok(flash_access_ok), .ctr_req(ctr_req),
        .ctr_exec_ext(ctr_exec_ext), .ctr_target_int(ctr_target_int), .ctr_valid(ctr_valid),
        .ctr_to_internal(ctr_to_internal), .ctr_redirected(ctr_redirected));

    task automatic complete_run();
        if (error_cnt == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic tick();
        @(posedge clk);
        #2;
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic prog_write(input logic [7:0] d, input logic exp_ref);
        prog_wr = 1'b1;
        prog_wdata = d;
        tick();
        prog_wr = 1'b0;
        chk_bit(prog_refused, exp_ref);
        tick();
    endtask

    task automatic prog_read(input logic [7:0] exp_d, input logic exp_ref);
        prog_rd = 1'b1;
        tick();
        prog_rd = 1'b0;
        chk_byte(prog_rdata, exp_d);
        chk_bit(prog_refused, exp_ref);
        tick();
    endtask

    task automatic erase_all();
        prog_erase_all = 1'b1;
        tick();
        prog_erase_all = 1'b0;
        tick();
    endtask

    // straps are set before reset rises and released after it falls, so the hold is seen
    task automatic boot(input logic pa, input logic pb, input logic pc, input logic exp);
        press_a = pa;
        press_b = pb;
        press_c = pc;
        tick();
        ext_reset = 1'b1;
        tick();
        tick();
        ext_reset = 1'b0;
        press_a = 1'b0;
        press_b = 1'b0;
        press_c = 1'b0;
        tick();
        tick();
        chk_bit(fetch_from_loader, exp);
    endtask

    task automatic fpc_write(input logic [7:0] v);
        fpc_wr = 1'b1;
        fpc_wdata = v;
        tick();
        fpc_wr = 1'b0;
    endtask

    task automatic idle_cmd(input logic [7:0] v, input logic ld, input logic rst, input logic upd);
        fpc_write(v);
        chk_byte(fpc_rdata, v);
        cpu_idle = 1'b1;
        tick();
        cpu_idle = 1'b0;
        chk_bit(fetch_from_loader, ld);
        chk_bit(sys_reset_req, rst);
        chk_bit(ldr_update_active, upd);
        tick();
        chk_bit(sys_reset_req, 1'b0);
    endtask

    task automatic restart_check(input logic exp_rst);
        fpc_write(`BSFS_FPC_SW_RESTART);
        chk_bit(sys_reset_req, exp_rst);
        chk_bit(fetch_from_loader, 1'b0);
        tick();
    endtask

    task automatic ctr_sweep(input logic inhibit_off);
        for (int i = 0; i < 4; i++) begin
            ctr_req = 1'b1;
            ctr_exec_ext = i[1];
            ctr_target_int = i[0];
            tick();
            ctr_req = 1'b0;
            chk_bit(ctr_valid, 1'b1);
            chk_bit(ctr_to_internal, i[0] & ~(i[1] & ~inhibit_off));
            chk_bit(ctr_redirected, i[0] & i[1] & ~inhibit_off);
            tick();
            chk_bit(ctr_valid, 1'b0);
        end
    endtask

    initial begin
        repeat (1000) @(posedge clk);
        error_cnt++;
        complete_run();
    end

    initial begin
        repeat (5) @(posedge clk);
        #2;
        arst_n = 1'b1;
        tick();
        chk_bit(fetch_from_loader, 1'b0);
        chk_byte(fpc_rdata, `BSFS_FPC_RESET);
        prog_mode = 1'b1;
        tick();
        chk_bit(flash_access_ok, 1'b1);
        prog_read(`BSFS_OPT_RESET, 1'b0);
        ctr_sweep(1'b1);
        prog_mode = 1'b0;
        tick();
        prog_read(8'h00, 1'b1);
        prog_write(8'h00, 1'b1);
        prog_mode = 1'b1;
        tick();
        prog_read(8'hFF, 1'b0);
        prog_write(8'hEF, 1'b0);
        prog_write(8'hFF, 1'b0);
        prog_read(8'hEF, 1'b0);
        boot(1'b1, 1'b1, 1'b0, 1'b1);
        boot(1'b1, 1'b0, 1'b0, 1'b0);
        boot(1'b0, 1'b0, 1'b1, 1'b0);
        prog_write(8'hDD, 1'b0);
        prog_read(8'hCD, 1'b0);
        boot(1'b0, 1'b0, 1'b1, 1'b1);
        boot(1'b1, 1'b1, 1'b1, 1'b1);
        restart_check(1'b1);
        ctr_sweep(1'b0);
        idle_cmd(`BSFS_FPC_LOADER_ENTRY, 1'b1, 1'b1, 1'b0);
        chk_byte(fpc_rdata, `BSFS_FPC_RESET);
        restart_check(1'b1);
        restart_check(1'b0);
        idle_cmd(`BSFS_FPC_LOADER_UPDATE, 1'b0, 1'b0, 1'b1);
        ldr_update_done = 1'b1;
        tick();
        ldr_update_done = 1'b0;
        chk_bit(ldr_update_active, 1'b0);
        chk_bit(fetch_from_loader, 1'b0);
        erase_all();
        prog_read(8'hFF, 1'b0);
        prog_write(8'hFE, 1'b0);
        chk_bit(flash_access_ok, 1'b0);
        prog_read(8'h00, 1'b1);
        prog_write(8'h00, 1'b1);
        erase_all();
        prog_read(8'hFF, 1'b0);
        // frozen clock: neither the option write nor the command may land
        clk_en = 1'b0;
        prog_write(8'h00, 1'b0);
        fpc_write(`BSFS_FPC_LOADER_ENTRY);
        chk_byte(fpc_rdata, `BSFS_FPC_RESET);
        clk_en = 1'b1;
        prog_read(8'hFF, 1'b0);
        complete_run();
    end
endmodule // tb_bsfs_top
`default_nettype wire
